// ### hw/mode_seq_pkg.sv
// Package with modes, commands and timing constants of the mode sequencer
package mode_seq_pkg;
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int RESET_HOLD_TIME_US = 10000;
  localparam int REQUEST_WINDOW_TIME_MS = 350;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_TIME_US * (CLK_FREQ_HZ / 1000000));
  localparam int REQUEST_WINDOW_CYCLES = (REQUEST_WINDOW_TIME_MS * (CLK_FREQ_HZ / 1000));
  localparam int CNT_W = 32;
  localparam logic [2:0] CMD_STANDBY = 3'h0;
  localparam logic [2:0] CMD_NORMAL = 3'h1;
  localparam logic [2:0] CMD_STOP = 3'h2;
  localparam logic [2:0] CMD_SLEEP = 3'h3;
  localparam logic [1:0] DBG_NONE = 2'h0;
  localparam logic [1:0] DBG_NORMAL = 2'h1;
  localparam logic [1:0] DBG_STANDBY = 2'h2;
  localparam logic [1:0] DBG_STOP = 2'h3;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_NREQ = 4'h1,
    ST_NORMAL = 4'h3,
    ST_STANDBY = 4'h2,
    ST_STOP = 4'h6,
    ST_SLEEP = 4'h7,
    ST_FLASH = 4'h5
  } mode_type;

  typedef struct packed {
    mode_type mode;
    logic [CNT_W-1:0] cnt;
    logic from_sleep;
    logic [1:0] dbg;
    logic rst_n;
    logic main_on;
    logic main_lp;
    logic aux_on;
    logic hs_on;
    logic wd_run;
    logic can_active;
    logic fault_n;
    logic wd_load;
  } state_type;
endpackage : mode_seq_pkg

// ### hw/sbc_mode_sequencer.sv
// Operating-mode sequencer of the system basis chip
`timescale 1ns/10ps
// Functional notes
// - Host selects Standby, Normal, Stop or Sleep
// - Normal Request entered automatically after Reset/Stop wake
// - Undervoltage or watchdog faults force Reset mode, except in Sleep and Flash; watchdog faults do not in debug variants
// - Reset holds reset low, then Normal Request
// - Power-up and Sleep wake pass through Reset
// - Stop wake goes directly to Normal Request
// - Normal Request: main on, aux off, reset high
// - Entering Normal Request starts 350 ms window
// - Watchdog setup ends window, enters Normal/Standby
// - Debug variants via special sequence, watchdog halted
// - Flash programming disables reset, watchdog, CAN
// - Window timeout without setup loops through Reset
// - Window timeout after Sleep wake returns Sleep
module sbc_mode_sequencer
  import mode_seq_pkg::*;
#(
  parameter int RESET_HOLD_CNT = RESET_HOLD_CYCLES,
  parameter int REQUEST_WINDOW_CNT = REQUEST_WINDOW_CYCLES
)(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic MAIN_UNDERVOLTAGE,
  input wire logic WD_EXPIRED,
  input wire logic WD_CLOSED_SERVICE,
  input wire logic TIMING_SUBREG_WRITE,
  input wire logic TIMING_SUBREG_STANDBY,
  input wire logic MODE_CMD_VALID,
  input wire logic [2:0] MODE_CMD,
  input wire logic STOP_WD_ENABLE,
  input wire logic WAKE_EVENT,
  input wire logic MAIN_OVERCURRENT,
  input wire logic DEBUG_SEQ_VALID,
  input wire logic [1:0] DEBUG_SEQ_MODE,
  input wire logic FLASH_PROG,
  input wire logic HIGH_SIDE_SWITCH_REQ,
  output logic RESET_OUT_N,
  output logic MAIN_REG_ON,
  output logic MAIN_REG_LOW_POWER,
  output logic AUX_REGULATOR_ON,
  output logic HIGH_SIDE_SWITCH_ON,
  output logic WATCHDOG_RUN,
  output logic WATCHDOG_LOAD,
  output logic CAN_ACTIVE,
  output logic FAULT_FLAG_OUT_N,
  output logic [3:0] MODE_STATE
);

  state_type cur_ff;
  state_type nxt_ff;

  logic wd_fault;
  logic stop_wake;

  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.wd_load = 1'b0;
    // Watchdog faults ignored in debug variants
    wd_fault = (WD_EXPIRED | WD_CLOSED_SERVICE) & (cur_ff.dbg == DBG_NONE);
    // Overcurrent wake always armed in Stop
    stop_wake = WAKE_EVENT | MAIN_OVERCURRENT;
    if (cur_ff.cnt != '0)
    begin
      nxt_ff.cnt = cur_ff.cnt - 1'b1;
    end
    case (cur_ff.mode)
      ST_RESET:
      begin
        if (cur_ff.cnt == '0)
        begin
          nxt_ff.mode = ST_NREQ;
          nxt_ff.cnt = CNT_W'(REQUEST_WINDOW_CNT - 1);
        end
      end
      ST_NREQ:
      begin
        if (TIMING_SUBREG_WRITE)
        begin
          nxt_ff.mode = TIMING_SUBREG_STANDBY ? ST_STANDBY : ST_NORMAL;
          nxt_ff.wd_load = 1'b1;
          nxt_ff.from_sleep = 1'b0;
        end
        else if (cur_ff.cnt == '0)
        begin
          if (cur_ff.from_sleep)
          begin
            nxt_ff.mode = ST_SLEEP;
          end
          else
          begin
            nxt_ff.mode = ST_RESET;
            nxt_ff.cnt = CNT_W'(RESET_HOLD_CNT - 1);
          end
        end
      end
      ST_NORMAL, ST_STANDBY:
      begin
        if (MODE_CMD_VALID)
        begin
          case (MODE_CMD)
            CMD_NORMAL: nxt_ff.mode = ST_NORMAL;
            CMD_STANDBY: nxt_ff.mode = ST_STANDBY;
            CMD_STOP: nxt_ff.mode = ST_STOP;
            CMD_SLEEP: nxt_ff.mode = ST_SLEEP;
            default: nxt_ff.mode = cur_ff.mode;
          endcase
        end
        else if (DEBUG_SEQ_VALID && DEBUG_SEQ_MODE != DBG_NONE)
        begin
          nxt_ff.dbg = DEBUG_SEQ_MODE;
          case (DEBUG_SEQ_MODE)
            DBG_NORMAL: nxt_ff.mode = ST_NORMAL;
            DBG_STANDBY: nxt_ff.mode = ST_STANDBY;
            default: nxt_ff.mode = ST_STOP;
          endcase
        end
      end
      ST_STOP:
      begin
        if (stop_wake)
        begin
          nxt_ff.mode = ST_NREQ;
          nxt_ff.cnt = CNT_W'(REQUEST_WINDOW_CNT - 1);
          nxt_ff.from_sleep = 1'b0;
          nxt_ff.dbg = DBG_NONE;
        end
      end
      ST_SLEEP:
      begin
        if (WAKE_EVENT)
        begin
          nxt_ff.mode = ST_RESET;
          nxt_ff.cnt = CNT_W'(RESET_HOLD_CNT - 1);
          nxt_ff.from_sleep = 1'b1;
        end
      end
      ST_FLASH:
      begin
        if (!FLASH_PROG)
        begin
          nxt_ff.mode = ST_RESET;
          nxt_ff.cnt = CNT_W'(RESET_HOLD_CNT - 1);
        end
      end
      default:
      begin
        nxt_ff.mode = ST_RESET;
        nxt_ff.cnt = CNT_W'(RESET_HOLD_CNT - 1);
      end
    endcase
    // Reset conditions override everything but flash programming and Sleep mode
    if (FLASH_PROG)
    begin
      nxt_ff.mode = ST_FLASH;
      nxt_ff.dbg = DBG_NONE;
      nxt_ff.wd_load = 1'b0;
    end
    else if ((MAIN_UNDERVOLTAGE || wd_fault) && cur_ff.mode != ST_SLEEP && cur_ff.mode != ST_FLASH)
    begin
      nxt_ff.mode = ST_RESET;
      nxt_ff.cnt = CNT_W'(RESET_HOLD_CNT - 1);
      nxt_ff.dbg = DBG_NONE;
      nxt_ff.from_sleep = 1'b0;
      nxt_ff.wd_load = 1'b0;
    end
    // Output levels decoded from the next mode
    nxt_ff.rst_n = 1'b1;
    nxt_ff.main_on = 1'b1;
    nxt_ff.main_lp = 1'b0;
    nxt_ff.aux_on = 1'b0;
    nxt_ff.hs_on = 1'b0;
    nxt_ff.wd_run = 1'b0;
    nxt_ff.can_active = 1'b0;
    case (nxt_ff.mode)
      ST_RESET: nxt_ff.rst_n = 1'b0;
      ST_NREQ: nxt_ff.rst_n = 1'b1;
      ST_NORMAL:
      begin
        nxt_ff.aux_on = 1'b1;
        nxt_ff.hs_on = HIGH_SIDE_SWITCH_REQ;
        nxt_ff.wd_run = (nxt_ff.dbg == DBG_NONE);
        nxt_ff.can_active = 1'b1;
      end
      ST_STANDBY:
      begin
        nxt_ff.hs_on = HIGH_SIDE_SWITCH_REQ;
        nxt_ff.wd_run = (nxt_ff.dbg == DBG_NONE);
      end
      ST_STOP:
      begin
        nxt_ff.main_lp = 1'b1;
        nxt_ff.wd_run = STOP_WD_ENABLE & (nxt_ff.dbg == DBG_NONE);
      end
      ST_SLEEP:
      begin
        nxt_ff.main_on = 1'b0;
        nxt_ff.rst_n = 1'b0;
      end
      default:
      begin
        nxt_ff.main_on = 1'b0;
        nxt_ff.rst_n = 1'b1;
      end
    endcase
    // Fault flag low from a watchdog fault until watchdog setup
    if (wd_fault && !FLASH_PROG)
    begin
      nxt_ff.fault_n = 1'b0;
    end
    else if (nxt_ff.wd_load)
    begin
      nxt_ff.fault_n = 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      cur_ff <= '0;
      cur_ff.mode <= ST_RESET;
      cur_ff.cnt <= CNT_W'(RESET_HOLD_CNT - 1);
      cur_ff.main_on <= 1'b1;
      cur_ff.fault_n <= 1'b1;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign RESET_OUT_N = cur_ff.rst_n;
  assign MAIN_REG_ON = cur_ff.main_on;
  assign MAIN_REG_LOW_POWER = cur_ff.main_lp;
  assign AUX_REGULATOR_ON = cur_ff.aux_on;
  assign HIGH_SIDE_SWITCH_ON = cur_ff.hs_on;
  assign WATCHDOG_RUN = cur_ff.wd_run;
  assign WATCHDOG_LOAD = cur_ff.wd_load;
  assign CAN_ACTIVE = cur_ff.can_active;
  assign FAULT_FLAG_OUT_N = cur_ff.fault_n;
  assign MODE_STATE = cur_ff.mode;

endmodule : sbc_mode_sequencer

// ### verif/mode_seq_assertions.sv
// Checker of the mode sequencer
`timescale 1ns/10ps
module mode_seq_assertions #(
  parameter int RESET_HOLD_CNT = 10,
  parameter int REQUEST_WINDOW_CNT = 20
)(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic MAIN_UNDERVOLTAGE,
  input wire logic WD_EXPIRED,
  input wire logic WD_CLOSED_SERVICE,
  input wire logic TIMING_SUBREG_WRITE,
  input wire logic TIMING_SUBREG_STANDBY,
  input wire logic WAKE_EVENT,
  input wire logic FLASH_PROG,
  input wire logic RESET_OUT_N,
  input wire logic MAIN_REG_ON,
  input wire logic AUX_REGULATOR_ON,
  input wire logic WATCHDOG_LOAD,
  input wire logic [3:0] MODE_STATE
);
  int rcnt_ff;
  int wcnt_ff;
  logic calm, rs, rq;
  assign calm = !(MAIN_UNDERVOLTAGE | WD_EXPIRED | WD_CLOSED_SERVICE | FLASH_PROG);
  assign rs = MODE_STATE == 4'h0;
  assign rq = MODE_STATE == 4'h1;
  always_ff @(posedge CLK)
  begin
    rcnt_ff <= (SRST || !rs) ? 0 : rcnt_ff + 1;
    wcnt_ff <= (SRST || !rq) ? 0 : wcnt_ff + 1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  reset_low_a: assert property (rs |-> !RESET_OUT_N)
    else $error("reset output high");
  hold_len_a: assert property (rq && $past(rs) |-> rcnt_ff == RESET_HOLD_CNT)
    else $error("reset hold length");
  request_outs_a: assert property (rq |-> MAIN_REG_ON && !AUX_REGULATOR_ON && RESET_OUT_N)
    else $error("request mode outputs");
  window_len_a: assert property (wcnt_ff <= REQUEST_WINDOW_CNT)
    else $error("request window too long");
  window_end_a: assert property (rq && !TIMING_SUBREG_WRITE && calm |=>
    rq == ($past(wcnt_ff) < REQUEST_WINDOW_CNT - 1)) else $error("request window length");
  setup_exit_a: assert property (rq && TIMING_SUBREG_WRITE && calm |=>
    WATCHDOG_LOAD && MODE_STATE == ($past(TIMING_SUBREG_STANDBY) ? 4'h2 : 4'h3)) else $error("setup exit");
  fault_entry_a: assert property (MODE_STATE inside {4'h1, 4'h2, 4'h3} && MAIN_UNDERVOLTAGE &&
    !FLASH_PROG |=> rs) else $error("undervoltage ignored");
  stop_wake_a: assert property (MODE_STATE == 4'h6 && WAKE_EVENT && calm |=> rq)
    else $error("stop wake");
  sleep_wake_a: assert property (MODE_STATE == 4'h7 && WAKE_EVENT && !FLASH_PROG |=> rs)
    else $error("sleep wake");
endmodule : mode_seq_assertions
bind sbc_mode_sequencer mode_seq_assertions #(.RESET_HOLD_CNT(RESET_HOLD_CNT),
  .REQUEST_WINDOW_CNT(REQUEST_WINDOW_CNT)) u_chk (.CLK, .SRST, .MAIN_UNDERVOLTAGE, .WD_EXPIRED,
  .WD_CLOSED_SERVICE, .TIMING_SUBREG_WRITE, .TIMING_SUBREG_STANDBY, .WAKE_EVENT, .FLASH_PROG,
  .RESET_OUT_N, .MAIN_REG_ON, .AUX_REGULATOR_ON, .WATCHDOG_LOAD, .MODE_STATE);

// ### verif/host_model.sv
// Host model that sets the watchdog period
`timescale 1ns/10ps
module host_model #(
  parameter int DLY = 3
)(
  input wire logic clk,
  input wire logic en,
  input wire logic stby,
  input wire logic [3:0] mode,
  output logic wr,
  output logic wr_stby
);
  int cnt = 0;
  // Writes the timing subregister inside the request window
  always @(negedge clk)
  begin
    cnt = (mode == 4'h1 && en) ? cnt + 1 : 0;
    wr <= (cnt == DLY);
    wr_stby <= (cnt == DLY) ? stby : !stby;
  end
endmodule : host_model

// ### verif/test_sbc_mode_sequencer.sv
// Testbench of the mode sequencer
`timescale 1ns/10ps
module test_sbc_mode_sequencer;
  import mode_seq_pkg::*;
  logic clk = 1'b0, srst = 1'b1, uv = 1'b0, wde = 1'b0, wdc = 1'b0, cv = 1'b0, wake = 1'b0;
  logic dv = 1'b0, fl = 1'b0, hsr = 1'b0, hen = 1'b1, hsb = 1'b0, wr, wsb;
  logic swe = 1'b0, oc = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic [1:0] dm = 2'h0;
  logic rst_n, mon, mlp, aux, hs, wdr, can, flt_n;
  logic [3:0] ms;
  int failures = 0, n_tests = 0, cyc = 0;
  `define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
  sbc_mode_sequencer #(.RESET_HOLD_CNT(10), .REQUEST_WINDOW_CNT(20)) u_dut (.CLK(clk), .SRST(srst),
    .MAIN_UNDERVOLTAGE(uv), .WD_EXPIRED(wde), .WD_CLOSED_SERVICE(wdc), .TIMING_SUBREG_WRITE(wr),
    .TIMING_SUBREG_STANDBY(wsb), .MODE_CMD_VALID(cv), .MODE_CMD(cmd), .STOP_WD_ENABLE(swe),
    .WAKE_EVENT(wake), .MAIN_OVERCURRENT(oc), .DEBUG_SEQ_VALID(dv), .DEBUG_SEQ_MODE(dm),
    .FLASH_PROG(fl), .HIGH_SIDE_SWITCH_REQ(hsr), .RESET_OUT_N(rst_n), .MAIN_REG_ON(mon),
    .MAIN_REG_LOW_POWER(mlp), .AUX_REGULATOR_ON(aux), .HIGH_SIDE_SWITCH_ON(hs), .WATCHDOG_RUN(wdr),
    .WATCHDOG_LOAD(), .CAN_ACTIVE(can), .FAULT_FLAG_OUT_N(flt_n), .MODE_STATE(ms));
  host_model u_host (.clk(clk), .en(hen), .stby(hsb), .mode(ms), .wr(wr), .wr_stby(wsb));
  always #5 clk = ~clk;
  task automatic close_out;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic pl(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pl
  task automatic cm(input logic [2:0] c);
    cmd = c;
    pl(cv);
  endtask : cm
  task automatic wm(input logic [3:0] m);
    int i;
    i = 0;
    while (ms !== m && i < 100)
    begin
      @(negedge clk);
      i++;
    end
    `CHK("mode", m, ms)
  endtask : wm
  task automatic t_boot;
    `CHK("rst_n", 1'b0, rst_n)
    wm(4'h1);
    `CHK("aux", 1'b0, aux)
    wm(4'h3);
    `CHK("can", 1'b1, can)
    `CHK("wd", 1'b1, wdr)
    $display("boot done");
  endtask : t_boot
  task automatic t_modes;
    hsr = 1'b1;
    cm(CMD_STANDBY);
    `CHK("mode", 4'h2, ms)
    `CHK("hs", 1'b1, hs)
    cm(3'h5);
    `CHK("mode", 4'h2, ms)
    cm(CMD_NORMAL);
    `CHK("aux", 1'b1, aux)
    cm(CMD_STOP);
    `CHK("lp", 1'b1, mlp)
    `CHK("wd", 1'b0, wdr)
    pl(wake);
    `CHK("mode", 4'h1, ms)
    wm(4'h3);
    swe = 1'b1;
    cm(CMD_STOP);
    `CHK("wd", 1'b1, wdr)
    pl(oc);
    `CHK("mode", 4'h1, ms)
    wm(4'h3);
    swe = 1'b0;
    $display("modes done");
  endtask : t_modes
  task automatic t_sleep;
    hen = 1'b0;
    cm(CMD_SLEEP);
    `CHK("main", 1'b0, mon)
    pl(wake);
    `CHK("mode", 4'h0, ms)
    wm(4'h1);
    wm(4'h7);
    hen = 1'b1;
    hsb = 1'b1;
    pl(wake);
    wm(4'h2);
    $display("sleep done");
  endtask : t_sleep
  task automatic t_fault;
    hsb = 1'b0;
    pl(uv);
    `CHK("mode", 4'h0, ms)
    hen = 1'b0;
    wm(4'h1);
    wm(4'h0);
    hen = 1'b1;
    wm(4'h3);
    pl(wdc);
    `CHK("mode", 4'h0, ms)
    wm(4'h3);
    `CHK("flt", 1'b1, flt_n)
    pl(wde);
    `CHK("flt", 1'b0, flt_n)
    wm(4'h3);
    `CHK("flt", 1'b1, flt_n)
    $display("fault done");
  endtask : t_fault
  task automatic t_debug;
    dm = DBG_NORMAL;
    pl(dv);
    pl(wde);
    `CHK("mode", 4'h3, ms)
    `CHK("wd", 1'b0, wdr)
    dm = DBG_STANDBY;
    pl(dv);
    `CHK("mode", 4'h2, ms)
    swe = 1'b1;
    dm = DBG_STOP;
    pl(dv);
    pl(wdc);
    `CHK("mode", 4'h6, ms)
    `CHK("wd", 1'b0, wdr)
    swe = 1'b0;
    fl = 1'b1;
    @(negedge clk);
    `CHK("mode", 4'h5, ms)
    fl = 1'b0;
    @(negedge clk);
    `CHK("mode", 4'h0, ms)
    wm(4'h3);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    `CHK("mode", 4'h0, ms)
    `CHK("rst_n", 1'b0, rst_n)
    `CHK("main", 1'b1, mon)
    wm(4'h3);
    $display("debug done");
  endtask : t_debug
  initial
  begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_boot();
    t_modes();
    t_sleep();
    t_fault();
    t_debug();
    close_out();
  end
endmodule : test_sbc_mode_sequencer
